// *** hdl/ccr_cfg.svh ***
/*
 * Constants for the comparator configuration register bank: register
 * addresses, field positions, write masks and reset values.
 * Assumes an 8-bit special-function-register bus with 8-bit addresses.
 */
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// Register addresses on the special-function-register bus
`define CCR_MODE_ADDR       8'h9C
`define CCR_MUX1_ADDR       8'h9E
`define CCR_MUX0_ADDR       8'h9F

// Mode register fields
`define CCR_MODE_RIE_BIT    5
`define CCR_MODE_FIE_BIT    4
`define CCR_MODE_MD_LSB     0
`define CCR_MODE_MD_MSB     1
`define CCR_MODE_WMASK      8'h33
`define CCR_MODE_RESET      8'h02

// Mux register fields
`define CCR_MUX_POS_LSB     0
`define CCR_MUX_POS_MSB     2
`define CCR_MUX_NEG_LSB     4
`define CCR_MUX_NEG_MSB     6
`define CCR_MUX_WMASK       8'h77
`define CCR_MUX_RESET       8'h00

// Highest selection code that maps to a pin; higher codes are reserved
`define CCR_SEL_MAX         3'h4
`define CCR_SEL_CODES       5

// Indices of the four comparator inputs in the decode tables
`define CCR_IN_CMP0_POS     0
`define CCR_IN_CMP0_NEG     1
`define CCR_IN_CMP1_POS     2
`define CCR_IN_CMP1_NEG     3
`define CCR_IN_COUNT        4

`endif

// *** hdl/ccr_pkg.sv ***
/*
 * Types shared by the comparator configuration register bank.
 * Assumes ccr_cfg.svh is on the include path.
 */
package ccr_pkg;

    // One access on the special-function-register bus
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } ccr_sfr_req_t;

    // Port pin routed onto one comparator input
    typedef struct packed {
        logic       connect;
        logic [2:0] port;
        logic [2:0] bit_idx;
    } ccr_pin_sel_t;

    // Package variants with their own pin tables
    typedef enum logic {
        CCR_PKG_32PIN,
        CCR_PKG_48PIN
    } ccr_pkg_var_t;

endpackage

// *** hdl/ccr_pin_decode.sv ***
/*
 * Decodes a 3-bit comparator input selection into a port pin for one
 * comparator input and one package variant.
 * Assumes the selection and package variant are stable clock-domain levels;
 * the result is combinational and is registered by the caller.
 */
`timescale 1ns/1ps
`include "ccr_cfg.svh"

module ccr_pin_decode
    import ccr_pkg::*;
#(
    parameter int INPUT_IDX = 0
)
(
    input  wire logic [2:0]   sel_i,
    input  ccr_pkg_var_t      pkg_var_i,
    output ccr_pin_sel_t      pin_o
);

    function automatic ccr_pin_sel_t pn(input int p, input int b);
        pn = '{connect: 1'b1, port: p[2:0], bit_idx: b[2:0]};
    endfunction

    localparam ccr_pin_sel_t NC = '{connect: 1'b0, port: 3'h0, bit_idx: 3'h0};

    // Table index: input, package variant, selection code
    localparam ccr_pin_sel_t TBL [`CCR_IN_COUNT][2][`CCR_SEL_CODES] = '{
        '{ '{pn(1,0), pn(1,4), pn(2,0), pn(2,4), pn(0,0)},
           '{pn(2,0), pn(2,5), pn(3,4), pn(4,3), pn(0,3)} },
        '{ '{pn(1,1), pn(1,5), pn(2,1), pn(2,5), pn(0,1)},
           '{pn(2,1), pn(2,6), pn(3,5), pn(4,4), pn(0,4)} },
        '{ '{pn(1,2), pn(1,6), pn(2,2), NC,      pn(0,4)},
           '{pn(2,2), pn(3,0), pn(3,7), pn(4,5), pn(1,1)} },
        '{ '{pn(1,3), pn(1,7), pn(2,3), NC,      pn(0,5)},
           '{pn(2,3), pn(3,1), pn(4,0), pn(4,6), pn(1,2)} }
    };

    wire logic code_ok;

    assign code_ok = (sel_i <= `CCR_SEL_MAX);
    // Reserved codes leave the input floating from every pin
    assign pin_o = code_ok ? TBL[INPUT_IDX][pkg_var_i][sel_i] : NC;

endmodule

// *** hdl/ccr_regs.sv ***
/*
 * Comparator configuration register bank: Comparator1 mode selection,
 * Comparator1 edge flags and interrupt requests, and the input mux
 * selections of both comparators with their pin decode.
 * Assumes a single-cycle SFR bus in the clk_sys_i domain, an asynchronous
 * analog comparator output, and flag clear strobes from the Comparator1
 * control register on the same clock.
 */
`timescale 1ns/1ps
`include "ccr_cfg.svh"

// Functional notes
// - Mode bits 7:6, 3:2 read zero
// - Mode bit 5 gates rising-edge interrupt
// - Mode bit 4 gates falling-edge interrupt
// - Mode bits 1:0 drive comparator speed
// - Mux registers steer pins to comparators
// - Mux bits 2:0 pick positive input
// - Mux bits 6:4 pick negative input
// - Comparator0 negative codes 101-111 reserved
// - Mux bits 7 and 3 read zero
// - Rising edge sets sticky flag until cleared
module ccr_regs
    import ccr_pkg::*;
(
    input  wire logic          clk_sys_i,
    input  wire logic          sys_rst_i,
    input  ccr_sfr_req_t       sfr_req_i,
    output logic [7:0]         sfr_rdata_o,
    output logic               sfr_rvalid_o,
    input  wire logic          pkg_48pin_i,
    input  wire logic          cmp1_out_i,
    input  wire logic          cmp1_rise_flag_clr_i,
    input  wire logic          cmp1_fall_flag_clr_i,
    output logic               cmp1_rise_flag_o,
    output logic               cmp1_fall_flag_o,
    output logic               cmp1_rise_irq_o,
    output logic               cmp1_fall_irq_o,
    output logic [1:0]         cmp1_speed_power_mode_o,
    output ccr_pin_sel_t       cmp0_pos_pin_o,
    output ccr_pin_sel_t       cmp0_neg_pin_o,
    output ccr_pin_sel_t       cmp1_pos_pin_o,
    output ccr_pin_sel_t       cmp1_neg_pin_o
);

    logic [7:0]          mode_q;
    logic [7:0]          mode_d;
    logic [7:0]          mux0_q;
    logic [7:0]          mux0_d;
    logic [7:0]          mux1_q;
    logic [7:0]          mux1_d;
    logic [7:0]          rdata_q;
    logic [7:0]          rdata_d;
    logic                rvalid_q;
    logic                strap_sync1_q;
    logic                strap_sync2_q;
    logic                strap_done_q;
    ccr_pkg_var_t        pkg_var_q;
    logic                cmp_sync1_q;
    logic                cmp_sync2_q;
    logic                cmp_prev_q;
    logic                rise_flag_q;
    logic                rise_flag_d;
    logic                fall_flag_q;
    logic                fall_flag_d;
    logic                rise_irq_q;
    logic                fall_irq_q;
    ccr_pin_sel_t        pin_q [`CCR_IN_COUNT];
    ccr_pin_sel_t        pin_dec [`CCR_IN_COUNT];
    wire logic [2:0]     sel_code [`CCR_IN_COUNT];

    wire logic           hit_mode;
    wire logic           hit_mux0;
    wire logic           hit_mux1;
    wire logic           rise_evt;
    wire logic           fall_evt;

    // Address decode
    assign hit_mode = (sfr_req_i.addr == `CCR_MODE_ADDR);
    assign hit_mux1 = (sfr_req_i.addr == `CCR_MUX1_ADDR);
    assign hit_mux0 = (sfr_req_i.addr == `CCR_MUX0_ADDR);

    // Unimplemented bits are masked off on write so they always read zero
    assign mode_d = (sfr_req_i.wr && hit_mode)
                  ? (sfr_req_i.wdata & `CCR_MODE_WMASK) : mode_q;
    assign mux0_d = (sfr_req_i.wr && hit_mux0)
                  ? (sfr_req_i.wdata & `CCR_MUX_WMASK) : mux0_q;
    assign mux1_d = (sfr_req_i.wr && hit_mux1)
                  ? (sfr_req_i.wdata & `CCR_MUX_WMASK) : mux1_q;

    // Unmapped addresses read as zero
    assign rdata_d = !sfr_req_i.rd ? rdata_q
                   : hit_mode      ? mode_q
                   : hit_mux0      ? mux0_q
                   : hit_mux1      ? mux1_q
                   : 8'h00;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            mode_q   <= `CCR_MODE_RESET;
            mux0_q   <= `CCR_MUX_RESET;
            mux1_q   <= `CCR_MUX_RESET;
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            mode_q   <= mode_d;
            mux0_q   <= mux0_d;
            mux1_q   <= mux1_d;
            rdata_q  <= rdata_d;
            rvalid_q <= sfr_req_i.rd;
        end
    end

    // Strap pin is synchronised without reset so it has settled by release
    always_ff @(posedge clk_sys_i)
    begin
        strap_sync1_q <= pkg_48pin_i;
        strap_sync2_q <= strap_sync1_q;
    end

    // Package strap is sampled once, on the first edge after reset release;
    // the reset branch only loads constants.
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            strap_done_q <= 1'b0;
            pkg_var_q    <= CCR_PKG_32PIN;
        end
        else if (!strap_done_q)
        begin
            strap_done_q <= 1'b1;
            pkg_var_q    <= strap_sync2_q ? CCR_PKG_48PIN : CCR_PKG_32PIN;
        end
    end

    // Comparator output is asynchronous: two flops before any edge logic.
    // No reset here: the chain tracks the pin through reset, so a comparator
    // that is already high at release does not fake a rising edge.
    always_ff @(posedge clk_sys_i)
    begin
        cmp_sync1_q <= cmp1_out_i;
        cmp_sync2_q <= cmp_sync1_q;
        cmp_prev_q  <= cmp_sync2_q;
    end

    assign rise_evt = cmp_sync2_q & ~cmp_prev_q;
    assign fall_evt = ~cmp_sync2_q & cmp_prev_q;

    // A new edge in the clearing cycle wins, so no event is lost
    assign rise_flag_d = rise_evt | (rise_flag_q & ~cmp1_rise_flag_clr_i);
    assign fall_flag_d = fall_evt | (fall_flag_q & ~cmp1_fall_flag_clr_i);

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            rise_flag_q <= 1'b0;
            fall_flag_q <= 1'b0;
            rise_irq_q  <= 1'b0;
            fall_irq_q  <= 1'b0;
        end
        else
        begin
            rise_flag_q <= rise_flag_d;
            fall_flag_q <= fall_flag_d;
            // Level request follows the flag while enabled
            rise_irq_q  <= rise_flag_d & mode_d[`CCR_MODE_RIE_BIT];
            fall_irq_q  <= fall_flag_d & mode_d[`CCR_MODE_FIE_BIT];
        end
    end

    // Selection fields of both mux registers
    assign sel_code[`CCR_IN_CMP0_POS] = mux0_q[`CCR_MUX_POS_MSB:`CCR_MUX_POS_LSB];
    assign sel_code[`CCR_IN_CMP0_NEG] = mux0_q[`CCR_MUX_NEG_MSB:`CCR_MUX_NEG_LSB];
    assign sel_code[`CCR_IN_CMP1_POS] = mux1_q[`CCR_MUX_POS_MSB:`CCR_MUX_POS_LSB];
    assign sel_code[`CCR_IN_CMP1_NEG] = mux1_q[`CCR_MUX_NEG_MSB:`CCR_MUX_NEG_LSB];

    // Each decoder maps reserved codes to no pin
    for (genvar gi = 0; gi < `CCR_IN_COUNT; gi++)
    begin : g_dec
        ccr_pin_decode #(
            .INPUT_IDX (gi)
        ) u_dec (
            .sel_i     (sel_code[gi]),
            .pkg_var_i (pkg_var_q),
            .pin_o     (pin_dec[gi])
        );
    end

    // Pin routing is registered so the analog switches see glitch-free levels;
    // the cost is one cycle of latency after a mux write.
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < `CCR_IN_COUNT; i++)
            begin
                pin_q[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < `CCR_IN_COUNT; i++)
            begin
                pin_q[i] <= pin_dec[i];
            end
        end
    end

    // Chosen pins must be analog and skipped by the crossbar; not enforced here
    assign sfr_rdata_o             = rdata_q;
    assign sfr_rvalid_o            = rvalid_q;
    assign cmp1_rise_flag_o        = rise_flag_q;
    assign cmp1_fall_flag_o        = fall_flag_q;
    assign cmp1_rise_irq_o         = rise_irq_q;
    assign cmp1_fall_irq_o         = fall_irq_q;
    assign cmp1_speed_power_mode_o = mode_q[`CCR_MODE_MD_MSB:`CCR_MODE_MD_LSB];
    assign cmp0_pos_pin_o          = pin_q[`CCR_IN_CMP0_POS];
    assign cmp0_neg_pin_o          = pin_q[`CCR_IN_CMP0_NEG];
    assign cmp1_pos_pin_o          = pin_q[`CCR_IN_CMP1_POS];
    assign cmp1_neg_pin_o          = pin_q[`CCR_IN_CMP1_NEG];

endmodule

// *** testbench/ccr_cpu_model.sv ***
/* CPU-side model of the register bus: single-byte writes and reads.
   Assumes the bank answers a read on the taking edge itself, readable just after it. */
`timescale 1ns/1ps
module ccr_cpu_model
    import ccr_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] sfr_rdata_o,
    input  wire logic       sfr_rvalid_o,
    output ccr_sfr_req_t    sfr_req_o
);
    // Chosen comparator pins are taken as analog and skipped; no port setup here
    initial sfr_req_o = '0;

    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic v);
        @(posedge clk_sys_i);
        #1;
        sfr_req_o = '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge clk_sys_i);
        #1;
        q = sfr_rdata_o;
        v = sfr_rvalid_o;
        // Released lines flip so a stale address never passes for a request
        sfr_req_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
endmodule

// *** testbench/ccr_regs_assertions.sv ***
/* Port checker for the comparator configuration register bank.
   Bound to ccr_regs; sees only its ports, one clock domain. */
`timescale 1ns/1ps
module ccr_regs_chk
    import ccr_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    input  ccr_sfr_req_t    sfr_req_i,
    input  wire logic [7:0] sfr_rdata_o,
    input  wire logic       cmp1_out_i,
    input  wire logic       cmp1_rise_flag_clr_i,
    input  wire logic       cmp1_rise_flag_o,
    input  wire logic       cmp1_rise_irq_o,
    input  wire logic       cmp1_fall_irq_o,
    input  wire logic [1:0] cmp1_speed_power_mode_o,
    input  ccr_pin_sel_t    cmp0_neg_pin_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    wire mode_wr = sfr_req_i.wr && sfr_req_i.addr == 8'h9C;
    wire mux_rd  = sfr_req_i.rd && (sfr_req_i.addr == 8'h9E || sfr_req_i.addr == 8'h9F);

    property p_mode_rd;
        sfr_req_i.rd && sfr_req_i.addr == 8'h9C |=> (sfr_rdata_o & 8'hCC) == 8'h00;
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode spare bits read set");
    property p_mux_rd;
        mux_rd |=> (sfr_rdata_o & 8'h88) == 8'h00;
    endproperty
    a_mux_rd: assert property (p_mux_rd) else $error("mux spare bits read set");
    property p_mode_out;
        logic [1:0] v;
        (mode_wr, v = sfr_req_i.wdata[1:0]) |=> cmp1_speed_power_mode_o == v;
    endproperty
    a_mode_out: assert property (p_mode_out) else $error("speed mode not driven");
    property p_rise_gate;
        (mode_wr && !sfr_req_i.wdata[5]) ##1 !mode_wr |=> !cmp1_rise_irq_o;
    endproperty
    a_rise_gate: assert property (p_rise_gate) else $error("rise irq while off");
    property p_fall_gate;
        (mode_wr && !sfr_req_i.wdata[4]) ##1 !mode_wr |=> !cmp1_fall_irq_o;
    endproperty
    a_fall_gate: assert property (p_fall_gate) else $error("fall irq while off");
    property p_flag_hold;
        cmp1_rise_flag_o && !cmp1_rise_flag_clr_i |=> cmp1_rise_flag_o;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("rise flag lost");
    property p_flag_set;
        $rose(cmp1_out_i) |-> ##[2:4] cmp1_rise_flag_o;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("rise flag not set");
    property p_irq_flag;
        cmp1_rise_irq_o |-> cmp1_rise_flag_o;
    endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("rise irq without flag");
    property p_rsv_code;
        sfr_req_i.wr && sfr_req_i.addr == 8'h9F && sfr_req_i.wdata[6:4] > 3'h4
            |=> ##1 cmp0_neg_pin_o == 7'h00;
    endproperty
    a_rsv_code: assert property (p_rsv_code) else $error("reserved code connects");
endmodule

bind ccr_regs ccr_regs_chk u_chk (.clk_sys_i, .sys_rst_i, .sfr_req_i, .sfr_rdata_o,
    .cmp1_out_i, .cmp1_rise_flag_clr_i, .cmp1_rise_flag_o, .cmp1_rise_irq_o,
    .cmp1_fall_irq_o, .cmp1_speed_power_mode_o, .cmp0_neg_pin_o);

// *** testbench/testbench.sv ***
/* Self-checking testbench for the comparator configuration register bank.
   Assumes the CPU model and the checker are compiled before it. */
`timescale 1ns/1ps
module testbench
    import ccr_pkg::*;
;
    logic clk_sys_i = 0, sys_rst_i = 1, pkg_48pin_i = 0, cmp1_out_i = 0;
    logic cmp1_rise_flag_clr_i = 0, cmp1_fall_flag_clr_i = 0;
    logic cmp1_rise_flag_o, cmp1_fall_flag_o, cmp1_rise_irq_o, cmp1_fall_irq_o, sfr_rvalid_o, v;
    logic [7:0]   sfr_rdata_o, q;
    logic [1:0]   cmp1_speed_power_mode_o;
    ccr_sfr_req_t sfr_req_i;
    ccr_pin_sel_t cmp0_pos_pin_o, cmp0_neg_pin_o, cmp1_pos_pin_o, cmp1_neg_pin_o;
    int           failures = 0, cmp_count = 0;
    logic [6:0]   t0p [8] = '{7'h48, 7'h4C, 7'h50, 7'h54, 7'h40, 7'h00, 7'h00, 7'h00};
    logic [6:0]   t0n [8] = '{7'h49, 7'h4D, 7'h51, 7'h55, 7'h41, 7'h00, 7'h00, 7'h00};
    logic [6:0]   t1p [8] = '{7'h4A, 7'h4E, 7'h52, 7'h00, 7'h44, 7'h00, 7'h00, 7'h00};
    logic [6:0]   t1n [8] = '{7'h4B, 7'h4F, 7'h53, 7'h00, 7'h45, 7'h00, 7'h00, 7'h00};

    always #2 clk_sys_i = ~clk_sys_i;
    ccr_cpu_model u_cpu (.clk_sys_i, .sfr_rdata_o, .sfr_rvalid_o, .sfr_req_o(sfr_req_i));
    ccr_regs u_dut (.clk_sys_i, .sys_rst_i, .sfr_req_i, .sfr_rdata_o, .sfr_rvalid_o,
        .pkg_48pin_i, .cmp1_out_i, .cmp1_rise_flag_clr_i, .cmp1_fall_flag_clr_i,
        .cmp1_rise_flag_o, .cmp1_fall_flag_o, .cmp1_rise_irq_o, .cmp1_fall_irq_o,
        .cmp1_speed_power_mode_o, .cmp0_pos_pin_o, .cmp0_neg_pin_o, .cmp1_pos_pin_o,
        .cmp1_neg_pin_o);

    task automatic wrap_up();
        $display("failures=%0d comparisons=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_cpu.access(1'b1, a, d, q, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_cpu.access(1'b0, a, 8'h00, q, v);
        chk({7'h00, v}, 8'h01);
        chk(q, exp);
    endtask
    task automatic do_reset(input logic strap);
        sys_rst_i = 1'b1;
        pkg_48pin_i = strap;
        repeat (8) @(posedge clk_sys_i);
        #1;
        sys_rst_i = 1'b0;
    endtask
    task automatic chk_pins(input logic [6:0] a, b, c, d);
        @(posedge clk_sys_i);
        #1;
        chk({1'b0, cmp0_pos_pin_o}, {1'b0, a});
        chk({1'b0, cmp0_neg_pin_o}, {1'b0, b});
        chk({1'b0, cmp1_pos_pin_o}, {1'b0, c});
        chk({1'b0, cmp1_neg_pin_o}, {1'b0, d});
    endtask
    task automatic t_regs();
        rd(8'h9C, 8'h02);
        rd(8'h9E, 8'h00);
        rd(8'h9F, 8'h00);
        wr(8'h9C, 8'hFF);
        rd(8'h9C, 8'h33);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h9C, i[7:0]);
            chk({6'h00, cmp1_speed_power_mode_o}, i[7:0]);
        end
        wr(8'h9D, 8'hFF);
        rd(8'h9D, 8'h00);
        wr(8'h9E, 8'hFF);
        rd(8'h9E, 8'h77);
    endtask
    task automatic t_mux();
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h9F, {1'b1, c[2:0], 1'b1, c[2:0]});
            wr(8'h9E, {1'b1, c[2:0], 1'b1, c[2:0]});
            chk_pins(t0p[c], t0n[c], t1p[c], t1n[c]);
        end
    endtask
    // Mid-run reset with the other strap: the pin tables must follow it
    task automatic t_48pin();
        do_reset(1'b1);
        wr(8'h9F, 8'h12);
        wr(8'h9E, 8'h33);
        chk_pins(7'h5C, 7'h56, 7'h65, 7'h66);
    endtask
    task automatic t_edge(input logic lvl, input logic en);
        int n;
        n = 0;
        cmp1_out_i = lvl;
        while ((lvl ? cmp1_rise_flag_o : cmp1_fall_flag_o) !== 1'b1 && n < 8)
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        if (n == 8)
        begin
            failures++;
            wrap_up();
        end
        chk(n[7:0], 8'h03);
        chk({7'h00, lvl ? cmp1_rise_irq_o : cmp1_fall_irq_o}, {7'h00, en});
        cmp1_rise_flag_clr_i = lvl;
        cmp1_fall_flag_clr_i = !lvl;
        @(posedge clk_sys_i);
        #1;
        cmp1_rise_flag_clr_i = 1'b0;
        cmp1_fall_flag_clr_i = 1'b0;
        chk({6'h00, cmp1_rise_flag_o, cmp1_fall_flag_o}, 8'h00);
    endtask
    // A clear that meets a new edge must lose to it
    task automatic t_set_wins();
        cmp1_out_i = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
        cmp1_rise_flag_clr_i = 1'b1;
        @(posedge clk_sys_i);
        #1;
        chk({7'h00, cmp1_rise_flag_o}, 8'h01);
        @(posedge clk_sys_i);
        #1;
        cmp1_rise_flag_clr_i = 1'b0;
        chk({7'h00, cmp1_rise_flag_o}, 8'h00);
        t_edge(1'b0, 1'b0);
    endtask
    task automatic t_edges();
        wr(8'h9C, 8'h30);
        t_edge(1'b1, 1'b1);
        t_edge(1'b0, 1'b1);
        wr(8'h9C, 8'h00);
        t_edge(1'b1, 1'b0);
        t_edge(1'b0, 1'b0);
        t_set_wins();
    endtask

    initial
    begin
        do_reset(1'b0);
        t_regs();
        t_mux();
        t_edges();
        t_48pin();
        wrap_up();
    end
endmodule
